// File: logic/osd_cmd_pkg.sv
// constants and types shared by the command sequencing block
package osd_cmd_pkg;
    // ---------------------------------------------------------------
    // command words and codes
    // ---------------------------------------------------------------
    localparam logic [15:0] TEST_OSC_OUT_WORD = 16'hB03F;
    localparam logic [15:0] TEST_CLEAR_WORD = 16'hB000;
    localparam logic [7:0] END_CODE_128 = 8'h7F;
    localparam logic [7:0] END_CODE_256 = 8'hFF;
    localparam logic [1:0] CHAR_CMD_TOP = 2'h3;
    localparam int CHAR_CMD_BL_POS = 9;
    localparam logic [4:0] LAST_COLUMN = 5'h17;
    localparam logic [3:0] LAST_LINE = 4'hB;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLOCK_MHZ = 25;
    localparam int SHORT_CMD_GAP_NS = 2000;
    localparam int SHORT_CMD_GAP_CYCLES = (SHORT_CMD_GAP_NS * CLOCK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        IDLE_ST = 2'b00,
        SECOND_ST = 2'b01,
        RUN_ST = 2'b11
    } intake_state_type;

    typedef struct packed {
        logic blink;
        logic [3:0] line;
        logic [4:0] column;
        logic [7:0] code;
    } vram_write_type;
endpackage

// File: logic/osd_command_sequencing.sv
// serial command intake with contiguous character writes and test-mode sync routing
// Overview of operation
// - end code 7F or FF ends a contiguous run; characters stay below it.
// - test commands taken only while test pin is high.
// - oscillator command B03F in test mode puts oscillator on vsync output.
// - while so routed, vsync output carries no vertical sync.
// - same command routes dot-clock oscillator onto hsync output.
// - while so routed, hsync output carries no horizontal sync.
// - with display on, dot oscillator stops while hsync is low.
// - clear word B000 or test pin low leaves test mode.
// - characters written to video memory only while dot oscillator runs.
// - each abbreviated byte advances column, 23 wraps to 0 of next line.
module osd_command_sequencing
    import osd_cmd_pkg::*;
#(
    parameter bit WIDE_CHARSET = 1'b0
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // serial command pins
    input wire logic chip_select_n_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_i,
    // test and display
    input wire logic test_pin_i,
    input wire logic display_on_i,
    input wire logic lc_osc_enable_i,
    // oscillators and sync
    input wire logic crystal_osc_i,
    input wire logic lc_osc_i,
    input wire logic hsync_n_i,
    input wire logic vsync_n_i,
    // sync output pins
    output logic hsync_out_pin_o,
    output logic vsync_out_pin_o,
    // video memory write port, test mode and busy flags
    output logic vram_write_o,
    output vram_write_type vram_data_o,
    output logic test_mode_o,
    output logic short_cmd_gap_busy_o
);
    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [1:0] cs_sync_reg, sck_sync_reg, sda_sync_reg, test_sync_reg, disp_sync_reg;
    logic [1:0] lcen_sync_reg, xtal_sync_reg, lc_sync_reg, hs_sync_reg, vs_sync_reg;
    logic sck_last_reg;

    // two flops on every foreign input
    always_ff @(posedge clock_i) begin
        cs_sync_reg <= {cs_sync_reg[0], chip_select_n_i};
        sck_sync_reg <= {sck_sync_reg[0], serial_clock_i};
        sda_sync_reg <= {sda_sync_reg[0], serial_data_i};
        test_sync_reg <= {test_sync_reg[0], test_pin_i};
        disp_sync_reg <= {disp_sync_reg[0], display_on_i};
        lcen_sync_reg <= {lcen_sync_reg[0], lc_osc_enable_i};
        xtal_sync_reg <= {xtal_sync_reg[0], crystal_osc_i};
        lc_sync_reg <= {lc_sync_reg[0], lc_osc_i};
        hs_sync_reg <= {hs_sync_reg[0], hsync_n_i};
        vs_sync_reg <= {vs_sync_reg[0], vsync_n_i};
        sck_last_reg <= sck_sync_reg[1];
    end

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire cs_active = ~cs_sync_reg[1];
    wire sck_rise = sck_sync_reg[1] & ~sck_last_reg;
    wire test_high = test_sync_reg[1];
    // the end code follows the size of the character set
    wire [7:0] end_code = WIDE_CHARSET ? END_CODE_256 : END_CODE_128;
    // dot oscillator halts during low hsync while display is on
    wire lc_running = lcen_sync_reg[1] & ~(disp_sync_reg[1] & ~hs_sync_reg[1]);

    logic [7:0] shift_reg, shift_next;
    logic [2:0] bit_cnt_reg;
    logic [7:0] first_byte_reg;
    intake_state_type state_reg, state_next;
    logic test_mode_reg, osc_route_reg;
    logic [3:0] line_reg;
    logic [4:0] column_reg;
    logic blink_reg;
    logic [6:0] gap_cnt_reg;

    assign shift_next = {shift_reg[6:0], sda_sync_reg[1]};
    wire byte_done = cs_active & sck_rise & (bit_cnt_reg == 3'h7);
    wire [15:0] word = {first_byte_reg, shift_next};
    wire is_char_first = shift_next[7:6] == CHAR_CMD_TOP;
    wire is_two_byte = shift_next[7];
    wire is_osc_cmd = word == TEST_OSC_OUT_WORD;
    wire is_clear_cmd = word == TEST_CLEAR_WORD;
    wire char_byte = shift_next < end_code;
    wire write_now = byte_done & (state_reg == SECOND_ST || state_reg == RUN_ST)
        & first_byte_reg[7:6] == CHAR_CMD_TOP & char_byte;
    wire [4:0] col_inc = (column_reg == LAST_COLUMN) ? 5'h00 : column_reg + 5'h01;
    wire [3:0] line_inc = (line_reg == LAST_LINE) ? 4'h0 : line_reg + 4'h1;
    // a run opens only when the first character is a real one
    wire opens_run = (first_byte_reg[7:6] == CHAR_CMD_TOP) & char_byte;
    // a write attempted while the dot oscillator is halted is dropped
    wire write_kept = write_now & lc_running;

    // ---------------------------------------------------------------
    // intake state
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        // select going high abandons any partly received command
        if (!cs_active) begin
            state_next = IDLE_ST;
        end else if (byte_done) begin
            case (state_reg)
                IDLE_ST: state_next = is_two_byte ? SECOND_ST : IDLE_ST;
                SECOND_ST: state_next = opens_run ? RUN_ST : IDLE_ST;
                RUN_ST: state_next = char_byte ? RUN_ST : IDLE_ST;
                default: state_next = IDLE_ST;
            endcase
        end
    end

    // bit shifter and state
    always_ff @(posedge clock_i) begin
        if (reset_i || !cs_active) begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= shift_next;
        end
        if (reset_i) begin
            state_reg <= IDLE_ST;
            first_byte_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (byte_done && state_reg == IDLE_ST) begin
                first_byte_reg <= shift_next;
            end
        end
    end

    // ---------------------------------------------------------------
    // write position and video memory port
    // ---------------------------------------------------------------
    // each written character moves the column on, so the next abbreviated byte
    // lands one place to the right; the last column wraps to the next line
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            line_reg <= 4'h0;
            column_reg <= 5'h00;
            blink_reg <= 1'b0;
            vram_write_o <= 1'b0;
            vram_data_o <= '0;
        end else begin
            vram_write_o <= write_kept;
            if (byte_done && state_reg == IDLE_ST && is_char_first) begin
                blink_reg <= shift_next[CHAR_CMD_BL_POS - 8];
            end
            if (write_now) begin
                vram_data_o <= '{blink_reg, line_reg, column_reg, shift_next};
                column_reg <= col_inc;
                if (column_reg == LAST_COLUMN) begin
                    line_reg <= line_inc;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // test mode and sync outputs
    // ---------------------------------------------------------------
    // the pin going low wins over any word arriving in the same cycle
    always_ff @(posedge clock_i) begin
        if (reset_i || !test_high) begin
            test_mode_reg <= 1'b0;
            osc_route_reg <= 1'b0;
        end else if (byte_done && state_reg == SECOND_ST) begin
            if (is_osc_cmd) begin
                test_mode_reg <= 1'b1;
                osc_route_reg <= 1'b1;
            end else if (is_clear_cmd) begin
                test_mode_reg <= 1'b0;
                osc_route_reg <= 1'b0;
            end
        end
    end

    // sync pins carry oscillators instead of sync while routed
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            vsync_out_pin_o <= 1'b1;
            hsync_out_pin_o <= 1'b1;
            test_mode_o <= 1'b0;
        end else begin
            vsync_out_pin_o <= osc_route_reg ? xtal_sync_reg[1] : vs_sync_reg[1];
            hsync_out_pin_o <= osc_route_reg ? (lc_sync_reg[1] & lc_running)
                : hs_sync_reg[1];
            test_mode_o <= test_mode_reg;
        end
    end

    // busy indication after each completed command byte
    // every byte reloads the window, so it always counts from the last one
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            gap_cnt_reg <= 7'h00;
            short_cmd_gap_busy_o <= 1'b0;
        end else begin
            if (byte_done) begin
                gap_cnt_reg <= 7'(SHORT_CMD_GAP_CYCLES);
            end else if (gap_cnt_reg != 7'h00) begin
                gap_cnt_reg <= gap_cnt_reg - 7'h01;
            end
            short_cmd_gap_busy_o <= byte_done | (gap_cnt_reg > 7'h01);
        end
    end
endmodule

// File: verification/osd_cmd_checker.sv
// assertion checker for the command sequencing block
module osd_cmd_checker
    import osd_cmd_pkg::*;
#(
    parameter bit WIDE_CHARSET = 1'b0
) (
    // inputs of the block
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic test_pin_i,
    input wire logic display_on_i,
    input wire logic lc_osc_enable_i,
    input wire logic crystal_osc_i,
    input wire logic lc_osc_i,
    input wire logic hsync_n_i,
    input wire logic vsync_n_i,
    // outputs of the block
    input wire logic hsync_out_pin_o,
    input wire logic vsync_out_pin_o,
    input wire logic vram_write_o,
    input wire vram_write_type vram_data_o,
    input wire logic test_mode_o
);
    wire logic [7:0] end_code = WIDE_CHARSET ? END_CODE_256 : END_CODE_128;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // ---------------------------------------------------------------
    // sync routing and write refusal
    // ---------------------------------------------------------------
    AST_TEST_LEAVE: assert property (!test_pin_i [*5] |-> !test_mode_o)
        else $error("test mode with pin low");
    AST_VSYNC_PASS: assert property ((!test_mode_o && $stable(vsync_n_i)) [*5]
        |-> vsync_out_pin_o == vsync_n_i) else $error("vsync not passed");
    AST_HSYNC_PASS: assert property ((!test_mode_o && $stable(hsync_n_i)) [*5]
        |-> hsync_out_pin_o == hsync_n_i) else $error("hsync not passed");
    AST_VSYNC_OSC: assert property ((test_mode_o && $stable(crystal_osc_i)) [*5]
        |-> vsync_out_pin_o == crystal_osc_i) else $error("crystal not on vsync pin");
    AST_HSYNC_OSC: assert property ((test_mode_o && !display_on_i && lc_osc_enable_i
        && $stable(lc_osc_i)) [*5] |-> hsync_out_pin_o == lc_osc_i) else $error("dot osc not out");
    AST_CODE_BELOW: assert property (vram_write_o |-> vram_data_o.code < end_code)
        else $error("end code written");
    AST_OSC_OFF: assert property (!lc_osc_enable_i [*8] |-> !vram_write_o)
        else $error("write with oscillator off");
    AST_HSYNC_STOP: assert property ((display_on_i && !hsync_n_i) [*8] |-> !vram_write_o)
        else $error("write while dot osc stopped");
    // main scenarios reached
    cover property (vram_write_o);
    cover property ($rose(test_mode_o));
    cover property ($fell(test_mode_o));
endmodule

bind osd_command_sequencing osd_cmd_checker #(.WIDE_CHARSET(WIDE_CHARSET)) chk (.*);

// File: verification/osd_host_model.sv
// serial host model driving the command pins
module osd_host_model (
    // clock
    input wire logic clock_i,
    // serial command pins
    output logic chip_select_n_o,
    output logic serial_clock_o,
    output logic serial_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock idles high, select idles high
    initial begin
        chip_select_n_o = 1'h1;
        serial_clock_o = 1'h1;
        serial_data_o = 1'h0;
    end
    // select raised between commands for noise margin
    task automatic select(input logic level);
        @(posedge clock_i);
        chip_select_n_o <= level;
    endtask
    // one byte msb first, four clocks low then high, then the busy gap
    task automatic send(input logic [7:0] data, input int gap);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clock_i);
            serial_clock_o <= 1'h0;
            serial_data_o <= data[i];
            repeat (4) @(posedge clock_i);
            serial_clock_o <= 1'h1;
            repeat (3) @(posedge clock_i);
        end
        @(posedge clock_i);
        serial_data_o <= ~data[0]; // no stale bit after release
        repeat (gap) @(posedge clock_i);
    endtask
endmodule

// File: verification/tb_top.sv
// self-checking bench for the command sequencing block
module tb_top
    import osd_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'h0, reset_i = 1'h1, test_pin_i = 1'h0, display_on_i = 1'h0;
    logic lc_osc_enable_i = 1'h1, hs_low = 1'h0, cs_n, sck, sdata, vram_write, test_mode, blink;
    logic [12:0] osc_count = 13'h0;
    logic hsync_out, vsync_out, busy;
    wire xtal_osc = osc_count[3];
    wire lc_osc = osc_count[4];
    wire hsync_n = |osc_count[6:4] & !hs_low;
    wire vsync_n = |osc_count[12:10];
    logic [8:0] prev;
    logic [7:0] chars[26];
    vram_write_type vram_data;
    vram_write_type writes[$];
    int err_count = 0, total_checks = 0, seed = 3729;
    always #20 clock_i = ~clock_i;
    // oscillators and sync inputs from one free counter
    always @(posedge clock_i) osc_count <= osc_count + 13'h1;
    always @(posedge clock_i) if (vram_write === 1'h1) writes.push_back(vram_data);
    osd_command_sequencing #(.WIDE_CHARSET(1'h0)) dut (.clock_i(clock_i), .reset_i(reset_i),
        .chip_select_n_i(cs_n), .serial_clock_i(sck), .serial_data_i(sdata),
        .test_pin_i(test_pin_i), .display_on_i(display_on_i), .lc_osc_enable_i(lc_osc_enable_i),
        .crystal_osc_i(xtal_osc), .lc_osc_i(lc_osc), .hsync_n_i(hsync_n), .vsync_n_i(vsync_n),
        .hsync_out_pin_o(hsync_out), .vsync_out_pin_o(vsync_out), .vram_write_o(vram_write),
        .vram_data_o(vram_data), .test_mode_o(test_mode), .short_cmd_gap_busy_o(busy));
    osd_host_model host (.clock_i(clock_i), .chip_select_n_o(cs_n), .serial_clock_o(sck),
        .serial_data_o(sdata));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    // sync pins against oscillators or sync inputs, three cycles of lag allowed
    task automatic check_sync(input bit routed);
        repeat (64) begin
            @(posedge clock_i);
            if (osc_count[3:0] >= 4'h3) begin
                check("hsync_out", hsync_out, routed ? osc_count[4] : hsync_n);
            end
            if (routed ? (osc_count[2:0] >= 3'h3) : (osc_count[9:0] >= 10'h003)) begin
                check("vsync_out", vsync_out, routed ? osc_count[3] : vsync_n);
            end
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // whole two-byte command under one select
    task automatic command(input logic [15:0] word);
        host.select(1'h0);
        host.send(word[15:8], 55);
        host.send(word[7:0], 10);
        check("busy", busy, 1'h1);
        repeat (30) @(posedge clock_i);
        check("busy", busy, 1'h1);
        repeat (15) @(posedge clock_i);
        check("busy", busy, 1'h0);
        host.select(1'h1);
    endtask
    function automatic logic [8:0] next_pos(input logic [8:0] pos);
        return (pos[4:0] == LAST_COLUMN) ? {pos[8:5] + 4'h1, 5'h00} : pos + 9'h001;
    endfunction
    initial begin
        repeat (12) @(posedge clock_i);
        reset_i <= 1'h0;
        repeat (5) @(posedge clock_i);
        // test words refused, taken, cleared by word and by pin
        command(TEST_OSC_OUT_WORD);
        check("test_mode", test_mode, 1'h0);
        test_pin_i <= 1'h1;
        command(TEST_OSC_OUT_WORD);
        check("test_mode", test_mode, 1'h1);
        check_sync(1'h1);
        repeat (400) @(posedge clock_i);
        command(TEST_CLEAR_WORD);
        check("test_mode", test_mode, 1'h0);
        check_sync(1'h0);
        command(TEST_OSC_OUT_WORD);
        check("test_mode", test_mode, 1'h1);
        test_pin_i <= 1'h0;
        repeat (8) @(posedge clock_i);
        check("test_mode", test_mode, 1'h0);
        check_sync(1'h0);
        // random run across the column wrap, closed by the end code
        blink = 1'($random(seed));
        foreach (chars[i]) chars[i] = (i == 25) ? 8'h7E : 8'($unsigned($random(seed)) % 126);
        host.select(1'h0);
        host.send({CHAR_CMD_TOP, 4'h0, blink, 1'h0}, 55);
        foreach (chars[i]) host.send(chars[i], 760);
        host.send(END_CODE_128, 760);
        host.select(1'h1);
        check("writes", writes.size(), 26);
        foreach (chars[i]) begin
            check("code", writes[i].code, chars[i]);
            check("blink", writes[i].blink, blink);
        end
        check("first", {writes[0].line, writes[0].column}, 9'h000);
        for (int i = 1; i < 26; i++) begin
            prev = {writes[i - 1].line, writes[i - 1].column};
            check("position", {writes[i].line, writes[i].column}, next_pos(prev));
        end
        // writes lost while the dot oscillator is stopped
        for (int k = 0; k < 2; k++) begin
            {display_on_i, hs_low, lc_osc_enable_i} <= (k == 0) ? 3'h7 : 3'h0;
            host.select(1'h0);
            host.send({CHAR_CMD_TOP, 6'h00}, 55);
            host.send(8'h41, 760);
            host.select(1'h1);
            check("lost", writes.size(), 26);
        end
        report_and_stop();
    end
    // hang guard
    initial begin
        #3000000;
        err_count++;
        report_and_stop();
    end
endmodule
